// ---- rx_gain_pkg.sv ----
// Package with register map, field layout and types of the receiver gain override block
// Summary of operation
// - Fields always readable and writable; applied only while measurement_unit_enable is set.
// - Hold source select 0 gives normal control, 1 uses the freeze bit.
// - Writing 1 to loop reset returns the gain loop to maximum gain.
// - Auto gain disable 1 stops regulation; gain then follows the manual code.
// - Freeze bit 0 lets the loop run free, 1 freezes it.
// - Manual code 0 maximum, 1 medium, 2 minimum gain; 3 is reserved.
// - Manual code acts only while auto gain is disabled; otherwise stored only.
package rx_gain_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register map
	localparam logic [7:0] TEST_CTRL_OFFSET = 8'h3C;
	localparam logic [7:0] MEAS_CTRL_OFFSET = 8'h03;
	localparam logic [7:0] LOOP_STATUS_OFFSET = 8'h40;
	localparam logic [7:0] TEST_CTRL_RESET = 8'h00;
	localparam logic [7:0] TEST_CTRL_WMASK = 8'h3F;
	localparam logic [7:0] MEAS_CTRL_RESET = 8'h00;
	localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

	// Field positions
	localparam int HOLD_SEL_BIT = 5;
	localparam int LOOP_RST_BIT = 4;
	localparam int AUTO_OFF_BIT = 3;
	localparam int FREEZE_BIT = 2;
	localparam int GAIN_CODE_LSB = 0;
	localparam int MEAS_EN_BIT = 0;

	// Gain step codes
	localparam logic [1:0] GAIN_MAX = 2'h0;
	localparam logic [1:0] GAIN_MED = 2'h1;
	localparam logic [1:0] GAIN_MIN = 2'h2;

	typedef enum logic [3:0] {
		LOOP_AUTO = 4'h1,
		LOOP_FROZEN = 4'h2,
		LOOP_MANUAL = 4'h4,
		LOOP_RESET = 4'h8
	} loop_mode_t;

	// Fields of the override register as applied to the receiver
	typedef struct packed {
		logic hold_sel;
		logic loop_rst;
		logic auto_off;
		logic freeze;
		logic [1:0] gain_code;
	} gain_ctrl_t;

endpackage : rx_gain_pkg

// ---- rx_gain_override_control.sv ----
// Receiver gain override register block with Avalon-MM slave
`timescale 1ns/1ns
module rx_gain_override_control
	import rx_gain_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic [7:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	output logic GAIN_LOOP_RESET,
	output logic GAIN_LOOP_FREEZE,
	output logic AUTO_GAIN_ENABLE,
	output logic [1:0] RX_GAIN_STEP,
	output logic [3:0] LOOP_MODE
);

	////////////////////////////////////////////////////////////////////////////////
	// Register state
	logic [7:0] test_ctrl_reg, test_ctrl_next;
	logic [7:0] meas_ctrl_reg, meas_ctrl_next;
	logic [31:0] rdata_reg, rdata_next;
	logic ack_reg, ack_next;
	logic req;
	logic wr_lane0;
	loop_mode_t loop_mode_reg, loop_mode_next;

	// Bus request is answered one cycle later; waitrequest high until then
	assign req = (AVS_READ | AVS_WRITE) & ~ack_reg;
	// Write lands only at the edge where the master sees waitrequest low
	assign wr_lane0 = AVS_WRITE & ack_reg & AVS_BYTEENABLE[0];

	// Next register values from bus writes
	always_comb begin
		test_ctrl_next = test_ctrl_reg;
		meas_ctrl_next = meas_ctrl_reg;
		rdata_next = rdata_reg;
		ack_next = req;
		if (wr_lane0 && AVS_ADDRESS == TEST_CTRL_OFFSET) begin
			test_ctrl_next = AVS_WRITEDATA[7:0] & TEST_CTRL_WMASK;
		end
		if (wr_lane0 && AVS_ADDRESS == MEAS_CTRL_OFFSET) begin
			meas_ctrl_next = {7'h00, AVS_WRITEDATA[MEAS_EN_BIT]};
		end
		if (AVS_READ && !ack_reg) begin
			case (AVS_ADDRESS)
				TEST_CTRL_OFFSET: rdata_next = {24'h000000, test_ctrl_reg};
				MEAS_CTRL_OFFSET: rdata_next = {24'h000000, meas_ctrl_reg};
				LOOP_STATUS_OFFSET: rdata_next = {28'h0000000, loop_mode_reg};
				default: rdata_next = UNMAPPED_READ;
			endcase
		end
	end

	// Register update; whole bank clears on reset
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			test_ctrl_reg <= TEST_CTRL_RESET;
			meas_ctrl_reg <= MEAS_CTRL_RESET;
			rdata_reg <= UNMAPPED_READ;
			ack_reg <= 1'b0;
		end else begin
			test_ctrl_reg <= test_ctrl_next;
			meas_ctrl_reg <= meas_ctrl_next;
			rdata_reg <= rdata_next;
			ack_reg <= ack_next;
		end
	end

	assign AVS_READDATA = rdata_reg;
	assign AVS_WAITREQUEST = ~ack_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Effective controls: reset values unless measurement unit is enabled
	gain_ctrl_t eff;
	logic loop_rst_reg, loop_rst_next;
	logic freeze_reg, freeze_next;
	logic auto_en_reg, auto_en_next;
	logic [1:0] step_reg, step_next;

	// Stored fields are gated, never altered, so reads still return them
	assign eff = meas_ctrl_reg[MEAS_EN_BIT] ? gain_ctrl_t'(test_ctrl_reg[5:0]) :
		gain_ctrl_t'(TEST_CTRL_RESET[5:0]);

	// Loop control decode
	always_comb begin
		loop_rst_next = eff.loop_rst;
		freeze_next = eff.hold_sel & eff.freeze;
		auto_en_next = ~eff.auto_off;
		// Code 3 is reserved; treated as minimum gain to stay safe
		step_next = GAIN_MAX;
		if (eff.auto_off) begin
			step_next = (eff.gain_code == GAIN_MED) ? GAIN_MED :
				(eff.gain_code == GAIN_MAX) ? GAIN_MAX : GAIN_MIN;
		end
		if (eff.loop_rst) begin
			loop_mode_next = LOOP_RESET;
		end else if (eff.auto_off) begin
			loop_mode_next = LOOP_MANUAL;
		end else if (freeze_next) begin
			loop_mode_next = LOOP_FROZEN;
		end else begin
			loop_mode_next = LOOP_AUTO;
		end
	end

	// Registered outputs
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			loop_rst_reg <= 1'b0;
			freeze_reg <= 1'b0;
			auto_en_reg <= 1'b1;
			step_reg <= GAIN_MAX;
			loop_mode_reg <= LOOP_AUTO;
		end else begin
			loop_rst_reg <= loop_rst_next;
			freeze_reg <= freeze_next;
			auto_en_reg <= auto_en_next;
			step_reg <= step_next;
			loop_mode_reg <= loop_mode_next;
		end
	end

	assign GAIN_LOOP_RESET = loop_rst_reg;
	assign GAIN_LOOP_FREEZE = freeze_reg;
	assign AUTO_GAIN_ENABLE = auto_en_reg;
	assign RX_GAIN_STEP = step_reg;
	assign LOOP_MODE = loop_mode_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	// Enable off forces reset controls
	// Guards the gate mux against a stale field
	chk_gate_by_enable: assert property (@(posedge CLK_SYS) disable iff (RST)
		!meas_ctrl_reg[MEAS_EN_BIT] |=> !GAIN_LOOP_FREEZE && AUTO_GAIN_ENABLE && !GAIN_LOOP_RESET)
		else $error("controls applied while measurement unit off");

	// Freeze only after hold source select
	// Catches a freeze leaking from normal mode
	chk_freeze_needs_sel: assert property (@(posedge CLK_SYS) disable iff (RST)
		GAIN_LOOP_FREEZE |-> $past(eff.hold_sel))
		else $error("freeze without hold source select");

	// Loop reset reaches pin and mode
	// Reset has top priority in the mode decode
	chk_reset_follows: assert property (@(posedge CLK_SYS) disable iff (RST)
		eff.loop_rst |=> GAIN_LOOP_RESET && LOOP_MODE == LOOP_RESET)
		else $error("loop reset not applied");

	// Auto gain off follows the field
	// One cycle of output register latency
	chk_auto_disable: assert property (@(posedge CLK_SYS) disable iff (RST)
		eff.auto_off |=> !AUTO_GAIN_ENABLE)
		else $error("auto gain still on");

	// Freeze applied when selected
	// Both select and freeze bit must be set
	chk_freeze_apply: assert property (@(posedge CLK_SYS) disable iff (RST)
		(eff.hold_sel && eff.freeze) |=> GAIN_LOOP_FREEZE)
		else $error("freeze not applied");

	// Medium code gives medium step
	// Only while regulation is off
	chk_gain_code: assert property (@(posedge CLK_SYS) disable iff (RST)
		(eff.auto_off && eff.gain_code == GAIN_MED) |=> RX_GAIN_STEP == GAIN_MED)
		else $error("medium gain not selected");

	// Manual code ignored under auto gain
	// Stored code must not leak to the step
	chk_code_ignored: assert property (@(posedge CLK_SYS) disable iff (RST)
		!eff.auto_off |=> RX_GAIN_STEP == GAIN_MAX)
		else $error("manual code used under auto gain");

	// Reserved bits never stored
	// Write mask keeps them clear
	chk_reserved_zero: assert property (@(posedge CLK_SYS) disable iff (RST)
		test_ctrl_reg[7:6] == 2'h0)
		else $error("reserved bits set");

	// Idle bus keeps waitrequest high
	// No spurious completion without a request
	chk_wait_idle: assert property (@(posedge CLK_SYS) disable iff (RST)
		(!AVS_READ && !AVS_WRITE) |=> AVS_WAITREQUEST)
		else $error("waitrequest low without request");

	// Waitrequest low for one cycle only
	// A held request must not complete twice
	chk_wait_one_cycle: assert property (@(posedge CLK_SYS) disable iff (RST)
		!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low too long");

	// Every request answered next cycle
	// Software may access at any time
	chk_req_answered: assert property (@(posedge CLK_SYS) disable iff (RST)
		((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST)
		else $error("request not answered");

	// Override read shows no upper bits
	// Reserved bits read back as zero
	chk_read_zero_top: assert property (@(posedge CLK_SYS) disable iff (RST)
		(!AVS_WAITREQUEST && AVS_READ && AVS_ADDRESS == TEST_CTRL_OFFSET) |->
			AVS_READDATA[31:6] == 26'h0000000)
		else $error("override read has upper bits");

	// Enable register holds a single bit
	// Upper bits ignored on write
	chk_meas_upper: assert property (@(posedge CLK_SYS) disable iff (RST)
		meas_ctrl_reg[7:1] == 7'h00)
		else $error("enable register upper bits set");

	// Accepted write stores masked data
	// Checked at the completing edge only
	chk_write_lands: assert property (@(posedge CLK_SYS) disable iff (RST)
		(!AVS_WAITREQUEST && AVS_WRITE && AVS_BYTEENABLE[0] && AVS_ADDRESS == TEST_CTRL_OFFSET)
			|-> test_ctrl_next == (AVS_WRITEDATA[7:0] & TEST_CTRL_WMASK))
		else $error("write not stored");

	// No write while waitrequest high
	// A write must land exactly once
	chk_no_write_waiting: assert property (@(posedge CLK_SYS) disable iff (RST)
		AVS_WAITREQUEST |=> test_ctrl_reg == $past(test_ctrl_reg))
		else $error("write landed while waiting");

	// Auto gain on when field clear
	// Regulation is the default behaviour
	chk_auto_on: assert property (@(posedge CLK_SYS) disable iff (RST)
		!eff.auto_off |=> AUTO_GAIN_ENABLE)
		else $error("auto gain off unexpectedly");

	// Minimum code gives minimum step
	// Covers the far end of the table
	chk_step_min: assert property (@(posedge CLK_SYS) disable iff (RST)
		(eff.auto_off && eff.gain_code == GAIN_MIN) |=> RX_GAIN_STEP == GAIN_MIN)
		else $error("minimum gain not selected");

	// Maximum code gives maximum step
	// Covers the near end of the table
	chk_step_max: assert property (@(posedge CLK_SYS) disable iff (RST)
		(eff.auto_off && eff.gain_code == GAIN_MAX) |=> RX_GAIN_STEP == GAIN_MAX)
		else $error("maximum gain not selected");

	// No loop reset without the field
	// Reset is a level, not sticky
	chk_no_reset: assert property (@(posedge CLK_SYS) disable iff (RST)
		!eff.loop_rst |=> !GAIN_LOOP_RESET)
		else $error("loop reset without request");

	// Loop runs free unless frozen
	// Freeze needs both select and hold bit
	chk_free_run: assert property (@(posedge CLK_SYS) disable iff (RST)
		!(eff.hold_sel && eff.freeze) |=> !GAIN_LOOP_FREEZE)
		else $error("loop frozen unexpectedly");

	// Manual mode when regulation off
	// Reset still takes precedence
	chk_manual_mode: assert property (@(posedge CLK_SYS) disable iff (RST)
		(eff.auto_off && !eff.loop_rst) |=> LOOP_MODE == LOOP_MANUAL)
		else $error("manual mode not entered");

	// Mode status is one-hot
	// Guards the state encoding
	chk_mode_onehot: assert property (@(posedge CLK_SYS) disable iff (RST)
		$onehot(LOOP_MODE))
		else $error("loop mode not one-hot");

	// Normal control never freezes
	// Select clear means normal operation
	chk_normal_ctrl: assert property (@(posedge CLK_SYS) disable iff (RST)
		!eff.hold_sel |=> !GAIN_LOOP_FREEZE)
		else $error("freeze in normal control");

	// Enable off gives reset step and mode
	// Stored code must not reach the receiver
	chk_stored_gated: assert property (@(posedge CLK_SYS) disable iff (RST)
		!meas_ctrl_reg[MEAS_EN_BIT] |=> RX_GAIN_STEP == GAIN_MAX && LOOP_MODE == LOOP_AUTO)
		else $error("gated step or mode wrong");

	// Enable register reads one bit
	// Upper read bits stay zero
	chk_rdata_meas: assert property (@(posedge CLK_SYS) disable iff (RST)
		(!AVS_WAITREQUEST && AVS_READ && AVS_ADDRESS == MEAS_CTRL_OFFSET) |->
			AVS_READDATA[31:1] == 31'h00000000)
		else $error("enable read has upper bits");

	// Unmapped reads return zero
	// Software may probe any address
	chk_unmapped_read: assert property (@(posedge CLK_SYS) disable iff (RST)
		(!AVS_WAITREQUEST && AVS_READ && AVS_ADDRESS != TEST_CTRL_OFFSET &&
			AVS_ADDRESS != MEAS_CTRL_OFFSET && AVS_ADDRESS != LOOP_STATUS_OFFSET) |->
			AVS_READDATA == UNMAPPED_READ)
		else $error("unmapped read not zero");

	// Frozen mode when only freeze applies
	// Lower priority than reset and manual
	chk_frozen_mode: assert property (@(posedge CLK_SYS) disable iff (RST)
		(eff.hold_sel && eff.freeze && !eff.auto_off && !eff.loop_rst) |=>
			LOOP_MODE == LOOP_FROZEN)
		else $error("frozen mode not entered");

	// Auto mode when nothing overrides
	// Normal operation is the fallback
	chk_auto_mode: assert property (@(posedge CLK_SYS) disable iff (RST)
		(!eff.loop_rst && !eff.auto_off && !(eff.hold_sel && eff.freeze)) |=>
			LOOP_MODE == LOOP_AUTO)
		else $error("auto mode not entered");

endmodule : rx_gain_override_control

// ---- tb_rx_gain_override_control.sv ----
// Self-checking testbench for the receiver gain override register block
`timescale 1ns/1ns
module tb_rx_gain_override_control
	import rx_gain_pkg::*;
;
	logic CLK_SYS = 1'b0;
	logic RST = 1'b1;
	logic [7:0] AVS_ADDRESS = 8'h00;
	logic AVS_READ = 1'b0;
	logic AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h00000000;
	logic [3:0] AVS_BYTEENABLE = 4'hF;
	logic [31:0] AVS_READDATA;
	logic AVS_WAITREQUEST;
	logic GAIN_LOOP_RESET;
	logic GAIN_LOOP_FREEZE;
	logic AUTO_GAIN_ENABLE;
	logic [1:0] RX_GAIN_STEP;
	logic [3:0] LOOP_MODE;
	int err_total = 0;
	int samples_checked = 0;

	rx_gain_override_control dut (.CLK_SYS(CLK_SYS), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .GAIN_LOOP_RESET(GAIN_LOOP_RESET),
		.GAIN_LOOP_FREEZE(GAIN_LOOP_FREEZE), .AUTO_GAIN_ENABLE(AUTO_GAIN_ENABLE),
		.RX_GAIN_STEP(RX_GAIN_STEP), .LOOP_MODE(LOOP_MODE));

	////////////////////////////////////////////////////////////////////////////////
	// Clock at 125 MHz
	initial begin
		forever #4 CLK_SYS = ~CLK_SYS;
	end

	task results;
		if (err_total == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : results

	task chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	// One bus access; an extra edge after release avoids double drive in one step
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
		int n;
		n = 0;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= {24'h000000, d};
		AVS_WRITE <= w;
		AVS_READ <= !w;
		do begin
			@(posedge CLK_SYS);
			n++;
		end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
		if (n >= 20 && AVS_WAITREQUEST !== 1'b0) begin
			err_total++;
			results;
		end
		q = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
		@(posedge CLK_SYS);
	endtask : acc

	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		acc(1'b1, a, d, q);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		acc(1'b0, a, 8'h00, q);
		chk(q, e);
	endtask : rd

	// Outputs lag the register by one cycle, so look one edge later
	task outs(input logic [8:0] e);
		@(posedge CLK_SYS);
		#1;
		chk({23'h0, GAIN_LOOP_RESET, GAIN_LOOP_FREEZE, AUTO_GAIN_ENABLE, RX_GAIN_STEP,
			LOOP_MODE}, {23'h0, e});
	endtask : outs

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (12) @(posedge CLK_SYS);
		RST <= 1'b0;
		outs(9'h041);
		rd(TEST_CTRL_OFFSET, 32'h00000000);
		wr(TEST_CTRL_OFFSET, 8'hFF);
		rd(TEST_CTRL_OFFSET, 32'h0000003F);
		outs(9'h041);
		wr(MEAS_CTRL_OFFSET, 8'h01);
		// Every legal manual gain step with regulation off
		for (int c = 0; c < 3; c++) begin
			wr(TEST_CTRL_OFFSET, 8'h08 | 8'(c));
			outs({3'b000, 2'(c), 4'h4});
		end
		wr(TEST_CTRL_OFFSET, 8'h0B);
		outs(9'h024);
		rd(MEAS_CTRL_OFFSET, 32'h00000001);
		wr(TEST_CTRL_OFFSET, 8'h02);
		outs(9'h041);
		wr(TEST_CTRL_OFFSET, 8'h24);
		outs(9'h0C2);
		wr(TEST_CTRL_OFFSET, 8'h04);
		outs(9'h041);
		wr(TEST_CTRL_OFFSET, 8'h10);
		outs(9'h148);
		rd(LOOP_STATUS_OFFSET, 32'h00000008);
		wr(TEST_CTRL_OFFSET, 8'h0A);
		wr(MEAS_CTRL_OFFSET, 8'h00);
		outs(9'h041);
		rd(TEST_CTRL_OFFSET, 32'h0000000A);
		AVS_BYTEENABLE <= 4'hE;
		wr(TEST_CTRL_OFFSET, 8'h3F);
		AVS_BYTEENABLE <= 4'hF;
		rd(TEST_CTRL_OFFSET, 32'h0000000A);
		rd(8'h20, 32'h00000000);
		results;
	end

endmodule : tb_rx_gain_override_control
